// [src/icc_regs.svh]
`ifndef ICC_REGS_SVH
`define ICC_REGS_SVH

// Coprocessor slot and register numbers
`define ICC_CP_NUM          4'h6
`define ICC_CR_IRQ_PEND     4'h0
`define ICC_CR_MASK         4'h1
`define ICC_CR_LEVEL        4'h2
`define ICC_CR_FIQ_PEND     4'h3
`define ICC_CR_ALL_PEND     4'h4
`define ICC_CR_HIGHEST      4'h5
`define ICC_CR_IRQ_PEND2    4'h6
`define ICC_CR_MASK2        4'h7
`define ICC_CR_LEVEL2       4'h8
`define ICC_CR_FIQ_PEND2    4'h9
`define ICC_CR_ALL_PEND2    4'hA

// Source vector shape
`define ICC_SRC_N           40
`define ICC_WORD_W          32
`define ICC_SECOND_W        8
`define ICC_SRC_VALID       40'h03_FFFF_FFFF
`define ICC_GPIO_COUNT      121
`define ICC_TIMER_COUNT     12
`define ICC_TIMER_DIRECT    4

// Reset values
`define ICC_PEND_RST        40'h00_0000_0000
`define ICC_MASK_RST        32'h0000_0000
`define ICC_LEVEL_RST       32'h0000_0000
`define ICC_SECOND_RST      8'h00

// Bit positions (equal to peripheral ID)
`define ICC_BIT_SYNCSER3    0
`define ICC_BIT_LINK        1
`define ICC_BIT_USBH2       2
`define ICC_BIT_USBH1       3
`define ICC_BIT_KEYPAD      4
`define ICC_BIT_MEMSTICK    5
`define ICC_BIT_PWRI2C      6
`define ICC_BIT_TIMER_HI    7
`define ICC_BIT_GPIO0       8
`define ICC_BIT_GPIO1       9
`define ICC_BIT_GPIOX       10
`define ICC_BIT_USBCLIENT   11
`define ICC_BIT_PERFMON     12
`define ICC_BIT_I2S         13
`define ICC_BIT_AC97        14
`define ICC_BIT_SMARTCARD   15
`define ICC_BIT_SSP2        16
`define ICC_BIT_LCD         17
`define ICC_BIT_I2C         18
`define ICC_BIT_INFRARED    19
`define ICC_BIT_SER_STD     20
`define ICC_BIT_SER_WLESS   21
`define ICC_BIT_SER_FULL    22
`define ICC_BIT_FLASHCARD   23
`define ICC_BIT_SSP1        24
`define ICC_BIT_DMA         25
`define ICC_BIT_TIMER0      26
`define ICC_BIT_RTC_TICK    30
`define ICC_BIT_RTC_ALARM   31
`define ICC_BIT_TRUSTED     32
`define ICC_BIT_CAPTURE     33

`endif

// [src/icc_pkg.sv]
`include "icc_regs.svh"

package icc_pkg;
    typedef logic [`ICC_SRC_N-1:0]    icc_src_vec_t;
    typedef logic [`ICC_WORD_W-1:0]   icc_word_t;
    typedef logic [`ICC_SECOND_W-1:0] icc_second_t;
    // Outcome of one coprocessor access
    typedef enum logic [1:0] {
        ICC_ACC_NONE,
        ICC_ACC_DONE,
        ICC_ACC_UNDEF
    } icc_acc_t;
endpackage

// [src/icc_source_map.sv]
`timescale 1ns/1ps
`default_nettype none
`include "icc_regs.svh"

module icc_source_map
    import icc_pkg::*;
#(
    parameter int GPIO_COUNT  = `ICC_GPIO_COUNT,
    parameter int TIMER_COUNT = `ICC_TIMER_COUNT
) (
    input  wire logic [GPIO_COUNT-1:0]  gpioEdge,
    input  wire logic [TIMER_COUNT-1:0] timerMatch,
    input  wire logic [21:0]            plainSrc,
    input  wire logic                   quickCaptureSrc,
    input  wire logic                   trustedModuleSrc,
    input  wire logic                   rtcAlarmSrc,
    input  wire logic                   rtcTickSrc,
    output icc_src_vec_t                rawSrc
);

    // Each peripheral ID is its bit position; unused positions stay zero
    always_comb begin
        rawSrc = '0;
        rawSrc[`ICC_BIT_CAPTURE]   = quickCaptureSrc;
        rawSrc[`ICC_BIT_TRUSTED]   = trustedModuleSrc;
        rawSrc[`ICC_BIT_RTC_ALARM] = rtcAlarmSrc;
        rawSrc[`ICC_BIT_RTC_TICK]  = rtcTickSrc;
        for (int t = 0; t < `ICC_TIMER_DIRECT; t++) begin
            rawSrc[`ICC_BIT_TIMER0 + t] = timerMatch[t];
        end
        rawSrc[`ICC_BIT_TIMER_HI]  = |timerMatch[TIMER_COUNT-1:`ICC_TIMER_DIRECT];
        rawSrc[`ICC_BIT_GPIO0]     = gpioEdge[0];
        rawSrc[`ICC_BIT_GPIO1]     = gpioEdge[1];
        rawSrc[`ICC_BIT_GPIOX]     = |gpioEdge[GPIO_COUNT-1:2];
        // Plain sources 25..11 then 6..0, packed high to low
        rawSrc[`ICC_BIT_DMA:`ICC_BIT_USBCLIENT] = plainSrc[21:7];
        rawSrc[`ICC_BIT_PWRI2C:`ICC_BIT_SYNCSER3] = plainSrc[6:0];
    end

endmodule
`default_nettype wire

// [src/icc_route.sv]
`timescale 1ns/1ps
`default_nettype none
`include "icc_regs.svh"

module icc_route
    import icc_pkg::*;
(
    input  wire icc_src_vec_t pending,
    input  wire icc_src_vec_t enable,
    input  wire icc_src_vec_t toFiq,
    output icc_src_vec_t      irqVec,
    output icc_src_vec_t      fiqVec
);

    // Masked sources never reach the core; level picks IRQ or FIQ
    assign irqVec = pending & enable & ~toFiq;
    assign fiqVec = pending & enable & toFiq;

endmodule
`default_nettype wire

// [src/icc_ctrl_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "icc_regs.svh"

// Notes on behaviour
// - Coprocessor access only from privileged mode
// - User-mode access raises undefined, changes nothing
// - Registers answer on coprocessor number six
// - CR0..CR10 map first then second set
// - Control and priority registers not reachable here
// - Every mapped register reads current contents
// - Only first mask and level are writable by coprocessor
// - Peripheral ID equals pending bit position
// - Bit 33 capture, bit 32 trusted module
// - Bit 31 alarm, bit 30 one-hertz tick
// - Bits 26..29 timers 0..3, bit 7 others
// - Bits 8, 9 pins 0, 1; 10 others
// - Bit 25 carries combined DMA request
// - Bits 22, 21, 20 full, wireless, standard serial
// - Bits 3, 2 USB host; 1 link; 0 serial
// - Pending registers read-only; only all-pending CR4, CR10 ignore mask
// - Pending set regardless of IRQ or FIQ level
// - Pending registers clear to zero at reset
// - Pending bit follows source status OR
// - Level bit routes each source to IRQ or FIQ
// - Masked source only updates pending, no interrupt
module icc_ctrl_top
    import icc_pkg::*;
#(
    parameter int GPIO_COUNT  = `ICC_GPIO_COUNT,
    parameter int TIMER_COUNT = `ICC_TIMER_COUNT
) (
    input  wire logic                   clock,
    input  wire logic                   rst_b,
    input  wire logic                   clkEn,
    input  wire logic                   cpReq,
    input  wire logic [3:0]             cpNum,
    input  wire logic [3:0]             cpRegNum,
    input  wire logic                   cpWrite,
    input  wire logic                   cpPriv,
    input  wire icc_word_t              cpWdata,
    input  wire icc_word_t              highestPriority,
    input  wire logic                   mmMaskSecondWe,
    input  wire logic                   mmLevelSecondWe,
    input  wire icc_second_t            mmWdataSecond,
    input  wire logic [GPIO_COUNT-1:0]  gpioEdge,
    input  wire logic [TIMER_COUNT-1:0] timerMatch,
    input  wire logic                   quickCaptureSrc,
    input  wire logic                   trustedModuleSrc,
    input  wire logic                   rtcAlarmSrc,
    input  wire logic                   rtcTickSrc,
    input  wire logic                   dmaSrc,
    input  wire logic                   syncSerialOneSrc,
    input  wire logic                   flashCardSrc,
    input  wire logic                   serialFullSrc,
    input  wire logic                   serialWirelessSrc,
    input  wire logic                   serialStandardSrc,
    input  wire logic                   infraredSrc,
    input  wire logic                   twoWireSrc,
    input  wire logic                   displaySrc,
    input  wire logic                   syncSerialTwoSrc,
    input  wire logic                   smartCardSrc,
    input  wire logic                   audioCodecSrc,
    input  wire logic                   audioSerialSrc,
    input  wire logic                   perfMonSrc,
    input  wire logic                   usbClientSrc,
    input  wire logic                   powerTwoWireSrc,
    input  wire logic                   memStickSrc,
    input  wire logic                   keypadSrc,
    input  wire logic                   usbHostOneSrc,
    input  wire logic                   usbHostTwoSrc,
    input  wire logic                   scalableLinkSrc,
    input  wire logic                   syncSerialThreeSrc,
    output logic                        cpDone,
    output logic                        cpUndef,
    output icc_word_t                   cpRdata,
    output logic                        irqToCore,
    output logic                        fiqToCore
);

    logic [1:0]   rstSync_ff;
    logic         rstSyncN;
    icc_src_vec_t rawSrc;
    icc_src_vec_t pending_ff;
    icc_word_t    mask_ff;
    icc_word_t    level_ff;
    icc_second_t  maskSecond_ff;
    icc_second_t  levelSecond_ff;
    icc_src_vec_t enableVec;
    icc_src_vec_t fiqSelVec;
    icc_src_vec_t irqVec;
    icc_src_vec_t fiqVec;
    logic         cpHit;
    logic         regMapped;
    icc_acc_t     nxt_acc;
    icc_word_t    nxt_rdata;
    logic         wrMask;
    logic         wrLevel;
    logic         done_ff;
    logic         undef_ff;
    icc_word_t    cpRdata_ff;
    logic         irqOut_ff;
    logic         fiqOut_ff;

    // Reset release through two flops; assert is immediate
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rstSync_ff <= 2'h0;
        end else if (clkEn) begin
            rstSync_ff <= {rstSync_ff[0], 1'b1};
        end
    end
    assign rstSyncN = rstSync_ff[1];

    // Source mapping onto peripheral-ID bit positions
    icc_source_map #(
        .GPIO_COUNT  (GPIO_COUNT),
        .TIMER_COUNT (TIMER_COUNT)
    ) u_map (
        .gpioEdge         (gpioEdge),
        .timerMatch       (timerMatch),
        .plainSrc         ({dmaSrc, syncSerialOneSrc, flashCardSrc, serialFullSrc,
                            serialWirelessSrc, serialStandardSrc, infraredSrc, twoWireSrc,
                            displaySrc, syncSerialTwoSrc, smartCardSrc, audioCodecSrc,
                            audioSerialSrc, perfMonSrc, usbClientSrc, powerTwoWireSrc,
                            memStickSrc, keypadSrc, usbHostOneSrc, usbHostTwoSrc,
                            scalableLinkSrc, syncSerialThreeSrc}),
        .quickCaptureSrc  (quickCaptureSrc),
        .trustedModuleSrc (trustedModuleSrc),
        .rtcAlarmSrc      (rtcAlarmSrc),
        .rtcTickSrc       (rtcTickSrc),
        .rawSrc           (rawSrc)
    );

    // Pending simply tracks the source level, so clearing at the source clears it here
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pending_ff <= `ICC_PEND_RST;
        end else if (!rstSyncN) begin
            pending_ff <= `ICC_PEND_RST;
        end else if (clkEn) begin
            pending_ff <= rawSrc & `ICC_SRC_VALID;
        end
    end

    // Second-set enables and levels come only from the memory-mapped side
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            maskSecond_ff  <= `ICC_SECOND_RST;
            levelSecond_ff <= `ICC_SECOND_RST;
        end else if (!rstSyncN) begin
            maskSecond_ff  <= `ICC_SECOND_RST;
            levelSecond_ff <= `ICC_SECOND_RST;
        end else if (clkEn) begin
            if (mmMaskSecondWe) begin
                maskSecond_ff <= mmWdataSecond;
            end
            if (mmLevelSecondWe) begin
                levelSecond_ff <= mmWdataSecond;
            end
        end
    end

    assign enableVec = {maskSecond_ff, mask_ff};
    assign fiqSelVec = {levelSecond_ff, level_ff};

    icc_route u_route (
        .pending (pending_ff),
        .enable  (enableVec),
        .toFiq   (fiqSelVec),
        .irqVec  (irqVec),
        .fiqVec  (fiqVec)
    );

    // Decode one coprocessor access; foreign coprocessor numbers get no answer
    always_comb begin
        cpHit     = cpReq && (cpNum == `ICC_CP_NUM);
        regMapped = (cpRegNum <= `ICC_CR_ALL_PEND2);
        nxt_acc   = ICC_ACC_NONE;
        wrMask    = 1'b0;
        wrLevel   = 1'b0;
        if (cpHit) begin
            if (!cpPriv || !regMapped) begin
                nxt_acc = ICC_ACC_UNDEF;
            end else begin
                nxt_acc = ICC_ACC_DONE;
                wrMask  = cpWrite && (cpRegNum == `ICC_CR_MASK);
                wrLevel = cpWrite && (cpRegNum == `ICC_CR_LEVEL);
            end
        end
    end

    // Read mux; second-set words carry data in the low byte
    always_comb begin
        nxt_rdata = '0;
        unique case (cpRegNum)
            `ICC_CR_IRQ_PEND:  nxt_rdata = irqVec[`ICC_WORD_W-1:0];
            `ICC_CR_MASK:      nxt_rdata = mask_ff;
            `ICC_CR_LEVEL:     nxt_rdata = level_ff;
            `ICC_CR_FIQ_PEND:  nxt_rdata = fiqVec[`ICC_WORD_W-1:0];
            `ICC_CR_ALL_PEND:  nxt_rdata = pending_ff[`ICC_WORD_W-1:0];
            `ICC_CR_HIGHEST:   nxt_rdata = highestPriority;
            `ICC_CR_IRQ_PEND2: nxt_rdata = {24'h000000, irqVec[`ICC_SRC_N-1:`ICC_WORD_W]};
            `ICC_CR_MASK2:     nxt_rdata = {24'h000000, maskSecond_ff};
            `ICC_CR_LEVEL2:    nxt_rdata = {24'h000000, levelSecond_ff};
            `ICC_CR_FIQ_PEND2: nxt_rdata = {24'h000000, fiqVec[`ICC_SRC_N-1:`ICC_WORD_W]};
            `ICC_CR_ALL_PEND2: nxt_rdata = {24'h000000, pending_ff[`ICC_SRC_N-1:`ICC_WORD_W]};
            default:           nxt_rdata = '0;
        endcase
    end

    // First mask and level, the only words the coprocessor may change
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            mask_ff  <= `ICC_MASK_RST;
            level_ff <= `ICC_LEVEL_RST;
        end else if (!rstSyncN) begin
            mask_ff  <= `ICC_MASK_RST;
            level_ff <= `ICC_LEVEL_RST;
        end else if (clkEn) begin
            if (wrMask) begin
                mask_ff <= cpWdata;
            end
            if (wrLevel) begin
                level_ff <= cpWdata;
            end
        end
    end

    // Answer one cycle after the request; data held until the next successful read answer
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            done_ff    <= 1'b0;
            undef_ff   <= 1'b0;
            cpRdata_ff <= '0;
        end else if (!rstSyncN) begin
            done_ff    <= 1'b0;
            undef_ff   <= 1'b0;
            cpRdata_ff <= '0;
        end else if (clkEn) begin
            // Separate flops so both answer lines leave straight from a register
            done_ff  <= (nxt_acc != ICC_ACC_NONE);
            undef_ff <= (nxt_acc == ICC_ACC_UNDEF);
            if (nxt_acc == ICC_ACC_DONE && !cpWrite) begin
                cpRdata_ff <= nxt_rdata;
            end
        end
    end

    // Core lines registered, so a source costs two cycles to reach the core
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            irqOut_ff <= 1'b0;
            fiqOut_ff <= 1'b0;
        end else if (!rstSyncN) begin
            irqOut_ff <= 1'b0;
            fiqOut_ff <= 1'b0;
        end else if (clkEn) begin
            irqOut_ff <= |irqVec;
            fiqOut_ff <= |fiqVec;
        end
    end

    assign cpDone    = done_ff;
    assign cpUndef   = undef_ff;
    assign cpRdata   = cpRdata_ff;
    assign irqToCore = irqOut_ff;
    assign fiqToCore = fiqOut_ff;

    // Checks run on enabled edges only, since a low enable freezes everything
    default clocking icc_cb @(posedge clock iff clkEn);
    endclocking
    default disable iff (!rstSyncN);

    chk_user_undef: assert property (
        cpReq && cpNum == `ICC_CP_NUM && !cpPriv |=> cpDone && cpUndef
    ) else $error("user-mode access did not raise undefined");

    chk_user_nowrite: assert property (
        cpReq && cpNum == `ICC_CP_NUM && !cpPriv && cpWrite |=> $stable(mask_ff) && $stable(level_ff)
    ) else $error("user-mode write changed state");

    chk_cp_number: assert property (
        cpReq && cpNum != `ICC_CP_NUM |=> !cpDone
    ) else $error("answered a foreign coprocessor number");

    chk_unmapped_undef: assert property (
        cpReq && cpNum == `ICC_CP_NUM && cpPriv && cpRegNum > `ICC_CR_ALL_PEND2 |=> cpUndef
    ) else $error("unmapped register did not raise undefined");

    chk_mask_write: assert property (
        cpReq && cpNum == `ICC_CP_NUM && cpPriv && cpWrite && cpRegNum == `ICC_CR_MASK
        |=> mask_ff == $past(cpWdata) && cpDone && !cpUndef
    ) else $error("mask write not taken");

    chk_ro_write: assert property (
        cpReq && cpPriv && cpWrite && cpRegNum != `ICC_CR_MASK && cpRegNum != `ICC_CR_LEVEL
        |=> $stable(mask_ff) && $stable(level_ff)
    ) else $error("write to other register changed state");

    chk_level_read: assert property (
        cpReq && cpNum == `ICC_CP_NUM && cpPriv && !cpWrite && cpRegNum == `ICC_CR_LEVEL
        |=> cpRdata == $past(level_ff)
    ) else $error("level read returned wrong data");

    chk_pend_read: assert property (
        cpReq && cpNum == `ICC_CP_NUM && cpPriv && !cpWrite && cpRegNum == `ICC_CR_ALL_PEND2
        |=> cpRdata == {24'h000000, $past(pending_ff[`ICC_SRC_N-1:`ICC_WORD_W])}
    ) else $error("second pending read returned wrong data");

    chk_pend_follow: assert property (
        rstSyncN |=> pending_ff == ($past(rawSrc) & `ICC_SRC_VALID)
    ) else $error("pending did not follow sources");

    chk_reserved_zero: assert property (
        pending_ff[`ICC_SRC_N-1:`ICC_BIT_CAPTURE+1] == 6'h00
    ) else $error("reserved pending bit set");

    chk_masked_quiet: assert property (
        (pending_ff & enableVec) == '0 |=> !irqToCore && !fiqToCore
    ) else $error("masked source reached the core");

    chk_fiq_route: assert property (
        (pending_ff & enableVec & fiqSelVec) != '0 |=> fiqToCore
    ) else $error("fiq-level source did not raise fiq");

    chk_timer_or: assert property (
        rstSyncN && timerMatch[TIMER_COUNT-1:`ICC_TIMER_DIRECT] != '0 |=> pending_ff[`ICC_BIT_TIMER_HI]
    ) else $error("upper timer match not pending");

    // Own disable so the check still runs while reset holds the block
    chk_reset_pend: assert property (
        disable iff (1'b0) !rstSyncN |-> pending_ff == `ICC_PEND_RST
    ) else $error("pending not cleared during reset");

    chk_level_write: assert property (
        cpReq && cpNum == `ICC_CP_NUM && cpPriv && cpWrite && cpRegNum == `ICC_CR_LEVEL
        |=> level_ff == $past(cpWdata) && cpDone && !cpUndef
    ) else $error("level write not taken");

    chk_irq_route: assert property (
        (pending_ff & enableVec & ~fiqSelVec) != '0 |=> irqToCore
    ) else $error("irq-level source did not raise irq");

endmodule
`default_nettype wire

// [verif/icc_core_model.sv]
`timescale 1ns/1ps
`default_nettype none

// Core side of the coprocessor port; issues one access at a time
module icc_core_model
    import icc_pkg::*;
(
    input  wire logic  clock,
    input  wire logic  cpDone,
    input  wire logic  cpUndef,
    input  wire logic [31:0] cpRdata,
    output logic       cpReq,
    output logic [3:0] cpNum,
    output logic [3:0] cpRegNum,
    output logic       cpWrite,
    output logic       cpPriv,
    output icc_word_t  cpWdata
);
    logic sixOn;

    // Idle at time zero, slot six not yet enabled
    initial begin
        cpReq = 1'b0; cpNum = 4'h0; cpRegNum = 4'h0; cpWrite = 1'b0; cpPriv = 1'b1; cpWdata = '0;
        sixOn = 1'b0;
    end

    // Software enables slot six before any access
    task automatic enable_cp();
        sixOn = 1'b1;
    endtask

    // One access; qualifiers scrambled after release so stale values never help
    task automatic access(input logic [3:0] num, input logic [3:0] cr, input logic wr,
                          input logic priv, input icc_word_t wd,
                          output logic done, output logic undef, output icc_word_t rd);
        done = 1'b0;
        undef = 1'b0;
        rd = '0;
        if (sixOn) begin
            @(negedge clock);
            cpReq = 1'b1; cpNum = num; cpRegNum = cr; cpWrite = wr; cpWdata = wd;
            cpPriv = priv;
            for (int i = 0; i < 3 && !done; i++) begin
                @(negedge clock);
                done = cpDone; undef = cpUndef; rd = cpRdata;
                cpReq = 1'b0; cpRegNum = ~cpRegNum; cpWrite = ~cpWrite; cpWdata = ~cpWdata; cpPriv = 1'b1;
            end
        end
    endtask
endmodule

`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/1ps
`default_nettype none

module testbench
    import icc_pkg::*;
;
    logic        clock, rst_b, clkEn, cpReq, cpWrite, cpPriv, cpDone, cpUndef, irqToCore, fiqToCore;
    logic [3:0]  cpNum, cpRegNum;
    icc_word_t   cpWdata, cpRdata, hp, mask, level, rd;
    logic        mmMW, mmLW, dn, ud;
    icc_second_t mmWD, mask2, level2;
    logic [120:0] gpio;
    logic [11:0] tmr;
    logic [25:0] srcs;
    logic [31:0] r;
    logic [3:0]  ro [9] = '{4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA};
    int          n_mismatch = 0;
    int          compares = 0;

    icc_ctrl_top icc_ctrl_top_i (.clock(clock), .rst_b(rst_b), .clkEn(clkEn), .cpReq(cpReq), .cpNum(cpNum),
        .cpRegNum(cpRegNum), .cpWrite(cpWrite), .cpPriv(cpPriv), .cpWdata(cpWdata), .highestPriority(hp),
        .mmMaskSecondWe(mmMW), .mmLevelSecondWe(mmLW), .mmWdataSecond(mmWD), .gpioEdge(gpio),
        .timerMatch(tmr), .quickCaptureSrc(srcs[25]), .trustedModuleSrc(srcs[24]), .rtcAlarmSrc(srcs[23]),
        .rtcTickSrc(srcs[22]), .dmaSrc(srcs[21]), .syncSerialOneSrc(srcs[20]), .flashCardSrc(srcs[19]),
        .serialFullSrc(srcs[18]), .serialWirelessSrc(srcs[17]), .serialStandardSrc(srcs[16]),
        .infraredSrc(srcs[15]), .twoWireSrc(srcs[14]), .displaySrc(srcs[13]), .syncSerialTwoSrc(srcs[12]),
        .smartCardSrc(srcs[11]), .audioCodecSrc(srcs[10]), .audioSerialSrc(srcs[9]), .perfMonSrc(srcs[8]),
        .usbClientSrc(srcs[7]), .powerTwoWireSrc(srcs[6]), .memStickSrc(srcs[5]), .keypadSrc(srcs[4]),
        .usbHostOneSrc(srcs[3]), .usbHostTwoSrc(srcs[2]), .scalableLinkSrc(srcs[1]),
        .syncSerialThreeSrc(srcs[0]), .cpDone(cpDone), .cpUndef(cpUndef), .cpRdata(cpRdata),
        .irqToCore(irqToCore), .fiqToCore(fiqToCore));

    icc_core_model icc_core_model_i (.clock(clock), .cpDone(cpDone), .cpUndef(cpUndef), .cpRdata(cpRdata),
        .cpReq(cpReq), .cpNum(cpNum), .cpRegNum(cpRegNum), .cpWrite(cpWrite), .cpPriv(cpPriv),
        .cpWdata(cpWdata));

    // Free-running 250 MHz clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Pending picture built from the source inputs
    function automatic logic [39:0] expPend();
        return {6'h00, srcs[25:22], tmr[3:0], srcs[21:7], |gpio[120:2], gpio[1:0], |tmr[11:4], srcs[6:0]};
    endfunction

    function automatic icc_word_t expCr(input logic [3:0] cr, input logic [39:0] p);
        case (cr)
            4'h0: return p[31:0] & mask & ~level;
            4'h1: return mask;
            4'h2: return level;
            4'h3: return p[31:0] & mask & level;
            4'h4: return p[31:0];
            4'h5: return hp;
            4'h6: return {24'h000000, p[39:32] & mask2 & ~level2};
            4'h7: return {24'h000000, mask2};
            4'h8: return {24'h000000, level2};
            4'h9: return {24'h000000, p[39:32] & mask2 & level2};
            default: return {24'h000000, p[39:32]};
        endcase
    endfunction

    task automatic chk(input string what, input logic [39:0] seen, input logic [39:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic wrReg(input logic [3:0] cr, input logic priv, input icc_word_t wd);
        icc_core_model_i.access(4'h6, cr, 1'b1, priv, wd, dn, ud, rd);
    endtask

    // Second-set writes only exist on the memory-mapped strobes
    task automatic mmWrite(input logic isLevel, input icc_second_t d);
        @(negedge clock);
        mmMW = ~isLevel; mmLW = isLevel; mmWD = d;
        @(negedge clock);
        mmMW = 1'b0; mmLW = 1'b0; mmWD = ~d;
        if (isLevel) level2 = d; else mask2 = d;
    endtask

    // Every mapped register plus both core lines
    task automatic readAll();
        logic [39:0] p;
        p = expPend();
        chk("irq line", {39'h0, irqToCore}, {39'h0, |expCr(4'h0, p) | |expCr(4'h6, p)});
        chk("fiq line", {39'h0, fiqToCore}, {39'h0, |expCr(4'h3, p) | |expCr(4'h9, p)});
        for (int cr = 0; cr < 11; cr++) begin
            icc_core_model_i.access(4'h6, 4'(cr), 1'b0, 1'b1, 32'h0, dn, ud, rd);
            chk("read answer", {38'h0, dn, ud}, 40'h2);
            chk("read value", {8'h00, rd}, {8'h00, expCr(4'(cr), p)});
        end
    endtask

    // Watchdog sized well above the roughly 1300 cycles the sequence needs
    initial begin
        #80000;
        n_mismatch++;
        end_of_test();
    end

    // Main sequence: reset, corner, random, refusals
    initial begin
        rst_b = 1'b0; clkEn = 1'b1; hp = '0; mmMW = 1'b0; mmLW = 1'b0; mmWD = '0;
        gpio = '0; tmr = '0; srcs = '0; mask = '0; level = '0; mask2 = '0; level2 = '0; r = 32'h7;
        repeat (12) @(negedge clock);
        rst_b = 1'b1;
        repeat (3) @(negedge clock);
        icc_core_model_i.enable_cp();
        readAll();
        srcs = '1; tmr = '1; gpio = '1;
        repeat (3) @(negedge clock);
        readAll();
        repeat (30) begin
            r = lfsr(r); srcs = r[25:0]; tmr = r[31:20];
            r = lfsr(r); gpio = r[3] ? (121'(1) << r[10:4]) : '0; hp = lfsr(r);
            r = lfsr(r); wrReg(4'h1, 1'b1, r); mask = r;
            chk("mask write", {38'h0, dn, ud}, 40'h2);
            r = lfsr(r); wrReg(4'h2, 1'b1, r); level = r;
            r = lfsr(r); mmWrite(1'b0, r[7:0]); mmWrite(1'b1, r[15:8]);
            wrReg(ro[r[19:16] % 9], 1'b1, ~r);
            chk("ignored write", {38'h0, dn, ud}, 40'h2);
            repeat (3) @(negedge clock);
            readAll();
        end
        // Frozen clock enable: a new source must not reach the core line
        wrReg(4'h1, 1'b1, 32'hFFFF_FFFF);
        mask = 32'hFFFF_FFFF;
        wrReg(4'h2, 1'b1, 32'h0000_0000);
        level = 32'h0000_0000;
        srcs = '0;
        tmr = '0;
        gpio = '0;
        repeat (3) @(negedge clock);
        clkEn = 1'b0;
        srcs = 26'h000_0001;
        repeat (4) @(negedge clock);
        chk("frozen line", {39'h0, irqToCore}, 40'h0);
        clkEn = 1'b1;
        repeat (3) @(negedge clock);
        readAll();
        // Mid-run reset with a live source: outputs drop, registers return to zero
        rst_b = 1'b0;
        @(negedge clock);
        chk("reset outputs", {5'h00, cpRdata, irqToCore, fiqToCore, cpDone}, 40'h0);
        rst_b = 1'b1;
        mask = '0;
        level = '0;
        mask2 = '0;
        level2 = '0;
        repeat (3) @(negedge clock);
        readAll();
        wrReg(4'h1, 1'b0, ~mask);
        chk("user mode", {38'h0, dn, ud}, 40'h3);
        for (int cr = 11; cr < 16; cr++) begin
            icc_core_model_i.access(4'h6, 4'(cr), 1'b0, 1'b1, 32'h0, dn, ud, rd);
            chk("unmapped", {38'h0, dn, ud}, 40'h3);
        end
        for (int n = 0; n < 16; n++) begin
            if (n != 6) begin
                icc_core_model_i.access(4'(n), 4'h1, 1'b1, 1'b1, ~mask, dn, ud, rd);
                chk("foreign slot", {38'h0, dn, ud}, 40'h0);
            end
        end
        readAll();
        end_of_test();
    end
endmodule

`default_nettype wire
